// >>> design/hbs_defs.svh
`ifndef HBS_DEFS_SVH
`define HBS_DEFS_SVH
// register offsets (byte addresses, one 32-bit word each)
`define HBS_OFS_CTRL 8'h00
`define HBS_OFS_OVL_GAIN 8'h04
`define HBS_OFS_OFF_DELAY 8'h08
`define HBS_OFS_SPD_THR 8'h0C
`define HBS_OFS_WAIT 8'h10
`define HBS_OFS_PHASE_SEL 8'h14
`define HBS_OFS_STATUS 8'h18
`define HBS_OFS_IRQ_STAT 8'h1C
`define HBS_OFS_IRQ_MASK 8'h20
`define HBS_OFS_OVL_NOM 8'h24
// ctrl fields
`define HBS_CTRL_BRK_ASSIGN 0
// reset values
`define HBS_RST_GAIN 8'h64
`define HBS_RST_OFF_DELAY 10'h064
`define HBS_RST_SPD_THR 11'h064
`define HBS_RST_WAIT 11'h1F4
`define HBS_RST_PHASE 2'h0
`define HBS_RST_OVL_NOM 16'h2710
// setting limits
`define HBS_GAIN_MIN 8'h32
`define HBS_GAIN_MAX 8'h96
`define HBS_OFF_DELAY_MIN 10'h001
`define HBS_OFF_DELAY_MAX 10'h1F4
`define HBS_SPD_THR_MAX 11'h3E8
`define HBS_WAIT_MIN 11'h064
`define HBS_WAIT_MAX 11'h3E8
// timing: 1 ms tick from the 10 MHz clock
`define HBS_CLK_HZ 10000000
`define HBS_TICK_MS 1
`define HBS_TICK_CYC (`HBS_CLK_HZ / 1000 * `HBS_TICK_MS)
// irq bits
`define HBS_IRQ_BRAKE_ON 0
`define HBS_IRQ_BRAKE_OFF 1
`define HBS_IRQ_OVL 2
`define HBS_IRQ_PHASE 3
`endif

// >>> design/hbs_pkg.sv
package hbs_pkg;
   typedef enum logic [2:0] {
      HBS_IDLE = 3'b000,
      HBS_RUN = 3'b001,
      HBS_OFF_DLY = 3'b010,
      HBS_COAST = 3'b011,
      HBS_HOLD = 3'b100
   } hbs_state_e;
   typedef struct packed {
      logic servo_on;
      logic fault;
      logic fault_class2;
      logic over_travel;
      logic phase_lost;
      logic ovl_active;
   } hbs_in_s;
   typedef struct packed {
      logic motor_power;
      logic brake_output_n;
      logic brake_output_oe;
      logic phase_fault;
      logic phase_alarm;
      logic ovl_fault;
   } hbs_out_s;
endpackage

// >>> design/hbs_ms_timer.sv
`timescale 1ns/100ps
`include "hbs_defs.svh"
// millisecond counter; holds at zero whenever run drops
module hbs_ms_timer
   import hbs_pkg::*;
#(
   parameter int WIDTH = 11
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic tick,
   input wire logic run,
   input wire logic [WIDTH-1:0] limit,
   output logic done
);
   // elaboration check: a one-bit counter cannot hold any useful limit
   if (WIDTH < 2) begin : g_bad_width
      $error("hbs_ms_timer: WIDTH too small");
   end
   logic [WIDTH-1:0] cnt_reg;
   logic [WIDTH-1:0] cnt_next;
   wire at_limit = (cnt_reg >= limit);
   assign cnt_next = !run ? '0 : (tick && !at_limit) ? cnt_reg + 1'b1 : cnt_reg;
   assign done = run && at_limit;
   // restart on loss of trigger
   always_ff @(posedge ref_clk) begin
      if (!rst_n) cnt_reg <= '0;
      else cnt_reg <= cnt_next;
   end
endmodule // hbs_ms_timer

// >>> design/hbs_ovl_scaler.sv
`timescale 1ns/100ps
`include "hbs_defs.svh"
// overload fault timer, nominal ms time scaled by gain percent
module hbs_ovl_scaler
   import hbs_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic tick,
   input wire logic ovl_active,
   input wire logic [7:0] gain,
   input wire logic [15:0] nominal_ms,
   output logic ovl_fault
);
   logic [23:0] acc_reg;
   logic [23:0] acc_next;
   logic fault_reg;
   // limit = nominal*gain, counted in 100 units per ms so gain is live
   wire [23:0] limit = 24'(nominal_ms) * 24'(gain);
   wire hit = (acc_reg >= limit);
   assign acc_next = !ovl_active ? 24'h000000 : (tick && !hit) ? acc_reg + 24'h000064 : acc_reg;
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         acc_reg <= 24'h000000;
         fault_reg <= 1'b0;
      end else begin
         acc_reg <= acc_next;
         fault_reg <= ovl_active && hit;
      end
   end
   assign ovl_fault = fault_reg;
endmodule // hbs_ovl_scaler

// >>> design/hbs_brake_seq.sv
`timescale 1ns/100ps
`include "hbs_defs.svh"
module hbs_brake_seq
   import hbs_pkg::*;
#(
   parameter int TICK_CYC = `HBS_TICK_CYC
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire hbs_in_s ctl_in,
   input wire logic motor_stopped,
   input wire logic [10:0] motor_speed,
   output hbs_out_s ctl_out,
   output logic irq
);
   // elaboration check: the tick needs two cycles at least and must fit the 24-bit divider
   if (TICK_CYC < 2 || TICK_CYC > 16777216) begin : g_bad_tick
      $error("hbs_brake_seq: TICK_CYC out of range");
   end
   ////////////////////////////////////////////////////////////////////////
   // millisecond tick divider
   // the only rate in the block: every ms timer keys off this one-cycle enable
   logic [23:0] div_reg;
   logic tick;
   assign tick = (div_reg == 24'(TICK_CYC - 1));
   always_ff @(posedge ref_clk) begin
      if (!rst_n) div_reg <= 24'h000000;
      else div_reg <= tick ? 24'h000000 : div_reg + 24'h000001;
   end
   ////////////////////////////////////////////////////////////////////////
   // settings registers
   logic assign_req_reg;
   logic brk_assigned_reg;
   logic [7:0] gain_reg;
   logic [9:0] off_delay_reg;
   logic [10:0] spd_thr_reg;
   logic [10:0] wait_reg;
   logic [1:0] phase_sel_reg;
   logic [15:0] ovl_nom_reg;
   logic [3:0] irq_stat_reg;
   logic [3:0] irq_mask_reg;
   wire wr_ctrl = reg_wr && (reg_addr == `HBS_OFS_CTRL);
   wire wr_gain = reg_wr && (reg_addr == `HBS_OFS_OVL_GAIN);
   wire wr_dly = reg_wr && (reg_addr == `HBS_OFS_OFF_DELAY);
   wire wr_thr = reg_wr && (reg_addr == `HBS_OFS_SPD_THR);
   wire wr_wait = reg_wr && (reg_addr == `HBS_OFS_WAIT);
   wire wr_phase = reg_wr && (reg_addr == `HBS_OFS_PHASE_SEL);
   wire wr_istat = reg_wr && (reg_addr == `HBS_OFS_IRQ_STAT);
   wire wr_imask = reg_wr && (reg_addr == `HBS_OFS_IRQ_MASK);
   wire wr_nom = reg_wr && (reg_addr == `HBS_OFS_OVL_NOM);
   // out-of-range writes are dropped so settings always stay legal
   wire gain_ok = (reg_wdata[7:0] >= `HBS_GAIN_MIN) && (reg_wdata[7:0] <= `HBS_GAIN_MAX)
      && (reg_wdata[31:8] == 24'h000000);
   wire dly_ok = (reg_wdata[9:0] >= `HBS_OFF_DELAY_MIN) && (reg_wdata[9:0] <= `HBS_OFF_DELAY_MAX)
      && (reg_wdata[31:10] == 22'h000000);
   wire thr_ok = (reg_wdata[10:0] <= `HBS_SPD_THR_MAX) && (reg_wdata[31:11] == 21'h000000);
   wire wait_ok = (reg_wdata[10:0] >= `HBS_WAIT_MIN) && (reg_wdata[10:0] <= `HBS_WAIT_MAX)
      && (reg_wdata[31:11] == 21'h000000);
   wire phase_ok = (reg_wdata[31:0] <= 32'h00000002);
   wire assign_bit = reg_wdata[`HBS_CTRL_BRK_ASSIGN];
   // assignment takes hold at once; removal waits for reset (power cycle)
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         assign_req_reg <= 1'b0;
         brk_assigned_reg <= 1'b0;
      end else begin
         if (wr_ctrl) assign_req_reg <= assign_bit;
         if (wr_ctrl && assign_bit) brk_assigned_reg <= 1'b1;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         gain_reg <= `HBS_RST_GAIN;
         off_delay_reg <= `HBS_RST_OFF_DELAY;
         spd_thr_reg <= `HBS_RST_SPD_THR;
         wait_reg <= `HBS_RST_WAIT;
         phase_sel_reg <= `HBS_RST_PHASE;
         ovl_nom_reg <= `HBS_RST_OVL_NOM;
         irq_mask_reg <= 4'h0;
      end else begin
         if (wr_gain && gain_ok) gain_reg <= reg_wdata[7:0];
         if (wr_dly && dly_ok) off_delay_reg <= reg_wdata[9:0];
         if (wr_thr && thr_ok) spd_thr_reg <= reg_wdata[10:0];
         if (wr_wait && wait_ok) wait_reg <= reg_wdata[10:0];
         if (wr_phase && phase_ok) phase_sel_reg <= reg_wdata[1:0];
         if (wr_nom) ovl_nom_reg <= reg_wdata[15:0];
         if (wr_imask) irq_mask_reg <= reg_wdata[3:0];
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // sequencer
   hbs_state_e state_reg;
   hbs_state_e state_next;
   logic dly_done;
   logic wait_done;
   // both fault sources are driven further down; declared here because the sequencer reads them
   logic ovl_fault;
   logic phase_fault;
   wire fault_any = ctl_in.fault || ovl_fault || phase_fault;
   wire fault1 = fault_any && !ctl_in.fault_class2;
   wire slow = (motor_speed < spd_thr_reg);
   // class-two fault on ctl_in.fault takes the stopped timing at once, at any speed
   wire stop_path = motor_stopped || (ctl_in.fault_class2 && ctl_in.fault);
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         HBS_IDLE:
            if (ctl_in.servo_on && !fault_any) state_next = HBS_RUN;
         HBS_RUN:
            // without an assigned output there is no brake to time, so stop at once
            if (!brk_assigned_reg && (!ctl_in.servo_on || fault_any))
               state_next = HBS_IDLE;
            else if (fault1) state_next = HBS_COAST;
            else if (!ctl_in.servo_on || fault_any)
               state_next = stop_path ? HBS_OFF_DLY : HBS_COAST;
         HBS_OFF_DLY:
            if (fault1) state_next = HBS_IDLE;
            else if (dly_done) state_next = HBS_HOLD;
         HBS_COAST:
            if (slow || wait_done) state_next = HBS_HOLD;
         HBS_HOLD:
            if (!ctl_in.servo_on) state_next = HBS_IDLE;
         default: state_next = HBS_IDLE;
      endcase
   end
   always_ff @(posedge ref_clk) begin
      if (!rst_n) state_reg <= HBS_IDLE;
      else state_reg <= state_next;
   end
   hbs_ms_timer #(.WIDTH(11)) u_off_dly (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .tick(tick),
      .run(state_reg == HBS_OFF_DLY),
      .limit({1'b0, off_delay_reg}),
      .done(dly_done)
   );
   hbs_ms_timer #(.WIDTH(11)) u_wait (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .tick(tick),
      .run(state_reg == HBS_COAST),
      .limit(wait_reg),
      .done(wait_done)
   );
   hbs_ovl_scaler u_ovl (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .tick(tick),
      .ovl_active(ctl_in.ovl_active),
      .gain(gain_reg),
      .nominal_ms(ovl_nom_reg),
      .ovl_fault(ovl_fault)
   );
   ////////////////////////////////////////////////////////////////////////
   // phase loss handling: 0 fault, 1 fault+alarm, 2 none
   wire phase_fault_en = (phase_sel_reg != 2'h2);
   assign phase_fault = ctl_in.phase_lost && phase_fault_en;
   wire phase_alarm = ctl_in.phase_lost && (phase_sel_reg == 2'h1);
   ////////////////////////////////////////////////////////////////////////
   // outputs
   // brake stays released outside overtravel while running and while coasting down to the threshold or the wait;
   // without assignment the brake pin stays quiet
   wire release_want = (state_reg == HBS_RUN || state_reg == HBS_COAST)
      && !ctl_in.over_travel;
   wire brake_release = brk_assigned_reg && release_want;
   wire power_on = (state_reg == HBS_RUN) || (state_reg == HBS_OFF_DLY && brk_assigned_reg);
   logic brake_n_reg;
   logic power_reg;
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         brake_n_reg <= 1'b1;
         power_reg <= 1'b0;
      end else begin
         brake_n_reg <= !brake_release;
         power_reg <= power_on && !fault1;
      end
   end
   // one assignment for the whole carrier keeps a single driver on the port
   assign ctl_out = '{
      motor_power: power_reg,
      brake_output_n: brake_n_reg,
      brake_output_oe: brk_assigned_reg,
      phase_fault: phase_fault,
      phase_alarm: phase_alarm,
      ovl_fault: ovl_fault
   };
   ////////////////////////////////////////////////////////////////////////
   // interrupts: set wins over write-one clear
   // a level event such as a held fault keeps its bit set against every clear
   logic brake_n_d;
   always_ff @(posedge ref_clk) begin
      if (!rst_n) brake_n_d <= 1'b1;
      else brake_n_d <= brake_n_reg;
   end
   wire [3:0] ev = {phase_fault, ovl_fault, !brake_n_d && brake_n_reg,
      brake_n_d && !brake_n_reg};
   wire [3:0] clr = wr_istat ? reg_wdata[3:0] : 4'h0;
   always_ff @(posedge ref_clk) begin
      if (!rst_n) irq_stat_reg <= 4'h0;
      else irq_stat_reg <= (irq_stat_reg & ~clr) | ev;
   end
   assign irq = |(irq_stat_reg & irq_mask_reg);
   ////////////////////////////////////////////////////////////////////////
   // read port, data in the cycle after the strobe
   wire [31:0] status_word = {24'h000000, phase_alarm, phase_fault, ovl_fault,
      brk_assigned_reg, 1'b0, state_reg};
   wire [31:0] rd_mux =
      (reg_addr == `HBS_OFS_CTRL) ? {31'h00000000, assign_req_reg} :
      (reg_addr == `HBS_OFS_OVL_GAIN) ? {24'h000000, gain_reg} :
      (reg_addr == `HBS_OFS_OFF_DELAY) ? {22'h000000, off_delay_reg} :
      (reg_addr == `HBS_OFS_SPD_THR) ? {21'h000000, spd_thr_reg} :
      (reg_addr == `HBS_OFS_WAIT) ? {21'h000000, wait_reg} :
      (reg_addr == `HBS_OFS_PHASE_SEL) ? {30'h00000000, phase_sel_reg} :
      (reg_addr == `HBS_OFS_STATUS) ? status_word :
      (reg_addr == `HBS_OFS_IRQ_STAT) ? {28'h0000000, irq_stat_reg} :
      (reg_addr == `HBS_OFS_IRQ_MASK) ? {28'h0000000, irq_mask_reg} :
      (reg_addr == `HBS_OFS_OVL_NOM) ? {16'h0000, ovl_nom_reg} : 32'h00000000;
   always_ff @(posedge ref_clk) begin
      if (!rst_n) reg_rdata <= 32'h00000000;
      else reg_rdata <= reg_rd ? rd_mux : 32'h00000000;
   end
   ////////////////////////////////////////////////////////////////////////
   // assertions
   sequence s_fault1;
      fault1 && (state_reg == HBS_RUN || state_reg == HBS_OFF_DLY);
   endsequence
   a_fault_power_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_fault1 |=> !ctl_out.motor_power) else $error("power not removed on fault");
   a_overtravel_brake: assert property (@(posedge ref_clk) disable iff (!rst_n)
      ctl_in.over_travel |=> ctl_out.brake_output_n) else $error("brake released in overtravel");
   a_unassigned_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !brk_assigned_reg |-> ctl_out.brake_output_n && !ctl_out.brake_output_oe)
      else $error("brake driven while unassigned");
   a_assign_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n)
      brk_assigned_reg |=> brk_assigned_reg) else $error("assignment dropped");
   a_release_run: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (state_reg == HBS_RUN && brk_assigned_reg && !ctl_in.over_travel)
      |=> !ctl_out.brake_output_n) else $error("brake not released in run");
   a_coast_exit: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (state_reg == HBS_COAST && slow) |=> state_reg == HBS_HOLD)
      else $error("no brake below speed threshold");
   a_stop_path: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (state_reg == HBS_RUN && brk_assigned_reg && !ctl_in.servo_on && !fault_any
      && motor_stopped)
      |=> state_reg == HBS_OFF_DLY ##1 ctl_out.brake_output_n)
      else $error("stopped servo-off path wrong");
   a_phase_sel2: assert property (@(posedge ref_clk) disable iff (!rst_n)
      phase_sel_reg == 2'h2 |-> !ctl_out.phase_fault && !ctl_out.phase_alarm)
      else $error("phase fault with select 2");
   a_gain_range: assert property (@(posedge ref_clk) disable iff (!rst_n)
      gain_reg >= `HBS_GAIN_MIN && gain_reg <= `HBS_GAIN_MAX) else $error("gain out of range");
   a_tick_period: assert property (@(posedge ref_clk) disable iff (!rst_n)
      tick |=> !tick) else $error("tick longer than a cycle");
   // start, coast and hold behaviour
   sequence s_start;
      state_reg == HBS_IDLE && ctl_in.servo_on && !fault_any && brk_assigned_reg;
   endsequence
   sequence s_coast;
      state_reg == HBS_COAST && brk_assigned_reg && !ctl_in.over_travel;
   endsequence
   a_start_release: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_start ##1 !ctl_in.over_travel |=> !ctl_out.brake_output_n)
      else $error("brake not released with servo-on");
   a_coast_release: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_coast |=> !ctl_out.brake_output_n)
      else $error("brake applied above threshold");
   a_coast_power: assert property (@(posedge ref_clk) disable iff (!rst_n)
      state_reg == HBS_COAST |=> !ctl_out.motor_power)
      else $error("power on while coasting");
   a_wait_exit: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (state_reg == HBS_COAST && wait_done) |=> state_reg == HBS_HOLD)
      else $error("no brake after wait time");
   a_hold_brake: assert property (@(posedge ref_clk) disable iff (!rst_n)
      state_reg == HBS_HOLD |=> ctl_out.brake_output_n && !ctl_out.motor_power)
      else $error("brake not held");
   // stopped-motor timing and faults
   sequence s_off_dly;
      state_reg == HBS_OFF_DLY && !fault1;
   endsequence
   a_dly_power: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_off_dly |=> ctl_out.motor_power && ctl_out.brake_output_n)
      else $error("power or brake wrong during off delay");
   a_dly_fault: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (state_reg == HBS_OFF_DLY && fault1)
      |=> state_reg == HBS_IDLE && !ctl_out.motor_power) else $error("fault kept power on");
   a_class2_stop: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (state_reg == HBS_RUN && brk_assigned_reg && ctl_in.fault && ctl_in.fault_class2)
      |=> state_reg == HBS_OFF_DLY) else $error("class-two fault left stopped timing");
   a_unassigned_stop: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (state_reg == HBS_RUN && !brk_assigned_reg && !ctl_in.servo_on)
      |=> state_reg == HBS_IDLE) else $error("delay timed without assignment");
   // timers run only in their own state, so they restart on every entry
   a_dly_restart: assert property (@(posedge ref_clk) disable iff (!rst_n)
      state_reg != HBS_OFF_DLY |-> !dly_done)
      else $error("off delay timer ran outside its state");
   a_wait_restart: assert property (@(posedge ref_clk) disable iff (!rst_n)
      state_reg != HBS_COAST |-> !wait_done)
      else $error("wait timer ran outside its state");
   // phase-loss codes and setting ranges
   a_phase_sel0: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (phase_sel_reg == 2'h0 && ctl_in.phase_lost) |-> ctl_out.phase_fault && !ctl_out.phase_alarm)
      else $error("phase code 0 wrong");
   a_phase_sel1: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (phase_sel_reg == 2'h1 && ctl_in.phase_lost) |-> ctl_out.phase_fault && ctl_out.phase_alarm)
      else $error("phase code 1 wrong");
   a_phase_code: assert property (@(posedge ref_clk) disable iff (!rst_n)
      phase_sel_reg != 2'h3)
      else $error("illegal phase code");
   a_delay_range: assert property (@(posedge ref_clk) disable iff (!rst_n)
      off_delay_reg >= `HBS_OFF_DELAY_MIN && off_delay_reg <= `HBS_OFF_DELAY_MAX)
      else $error("off delay out of range");
   a_thr_range: assert property (@(posedge ref_clk) disable iff (!rst_n)
      spd_thr_reg <= `HBS_SPD_THR_MAX)
      else $error("speed threshold out of range");
   a_wait_range: assert property (@(posedge ref_clk) disable iff (!rst_n)
      wait_reg >= `HBS_WAIT_MIN && wait_reg <= `HBS_WAIT_MAX)
      else $error("wait time out of range");
endmodule // hbs_brake_seq

// >>> bench/hbs_motor_model.sv
`timescale 1ns/100ps
// motor and load behind the drive: follows the target while powered, coasts when unpowered with the brake released
module hbs_motor_model
   import hbs_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic motor_power,
   input wire logic brake_output_n,
   input wire logic [10:0] target_rpm,
   input wire logic [10:0] decel_rpm,
   output logic [10:0] motor_speed,
   output logic motor_stopped
);
   // shaft speed; an engaged holding brake clamps an unpowered shaft to standstill
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         motor_speed <= 11'h000;
      end else if (motor_power) begin
         motor_speed <= target_rpm;
      end else if (brake_output_n) begin
         motor_speed <= 11'h000;
      end else if (motor_speed > decel_rpm) begin
         motor_speed <= motor_speed - decel_rpm;
      end else begin
         motor_speed <= 11'h000;
      end
   end
   // zero speed is standstill; no slip is modelled, so a held shaft reads stopped
   assign motor_stopped = (motor_speed == 11'h000);
endmodule // hbs_motor_model

// >>> bench/hbs_brake_seq_bench.sv
`timescale 1ns/100ps
`include "hbs_defs.svh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin bad_count++; \
   $display("unexpected at %0t: got %h, want %h", $time, a, e); end end
module hbs_brake_seq_bench
   import hbs_pkg::*;
;
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] data;
      logic wr;
      logic [31:0] exp;
   } hbs_row_s;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   hbs_in_s cin = '0;
   hbs_in_s ctl_in = '0;
   hbs_out_s cout;
   logic irq;
   logic [10:0] motor_speed;
   logic motor_stopped;
   logic [10:0] target_rpm = 11'h000;
   logic [10:0] decel_rpm = 11'h000;
   int bad_count = 0;
   int checked = 0;
   int cycles = 0;
   int g;
   // register cases: reads of reset values, legal writes and refused out-of-range writes
   hbs_row_s rows [17] = '{
      '{`HBS_OFS_OVL_GAIN, 32'h0, 1'b0, 32'h64}, '{`HBS_OFS_OVL_GAIN, 32'h32, 1'b1, 32'h32},
      '{`HBS_OFS_OVL_GAIN, 32'h31, 1'b1, 32'h32}, '{`HBS_OFS_OVL_GAIN, 32'h97, 1'b1, 32'h32},
      '{`HBS_OFS_OVL_GAIN, 32'h96, 1'b1, 32'h96}, '{`HBS_OFS_OFF_DELAY, 32'h0, 1'b0, 32'h64},
      '{`HBS_OFS_OFF_DELAY, 32'h0, 1'b1, 32'h64}, '{`HBS_OFS_OFF_DELAY, 32'h1F5, 1'b1, 32'h64},
      '{`HBS_OFS_SPD_THR, 32'h0, 1'b0, 32'h64}, '{`HBS_OFS_SPD_THR, 32'h3E9, 1'b1, 32'h64},
      '{`HBS_OFS_WAIT, 32'h0, 1'b0, 32'h1F4}, '{`HBS_OFS_WAIT, 32'h63, 1'b1, 32'h1F4},
      '{`HBS_OFS_PHASE_SEL, 32'h0, 1'b0, 32'h0}, '{`HBS_OFS_PHASE_SEL, 32'h3, 1'b1, 32'h0},
      '{8'h40, 32'h0, 1'b0, 32'h0}, '{`HBS_OFS_OVL_NOM, 32'h0, 1'b0, 32'h2710},
      '{`HBS_OFS_STATUS, 32'h0, 1'b0, 32'h0}};

   // short tick so a millisecond is ten clocks
   hbs_brake_seq #(.TICK_CYC(10)) hbs_brake_seq_i (.ref_clk(ref_clk), .rst_n(rst_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .ctl_in(ctl_in), .motor_stopped(motor_stopped),
      .motor_speed(motor_speed), .ctl_out(cout), .irq(irq));
   hbs_motor_model hbs_motor_model_i (.ref_clk(ref_clk), .rst_n(rst_n),
      .motor_power(cout.motor_power), .brake_output_n(cout.brake_output_n),
      .target_rpm(target_rpm), .decel_rpm(decel_rpm), .motor_speed(motor_speed),
      .motor_stopped(motor_stopped));

   ////////////////////////////////////////////////////////////////////////////
   // 100 ns clock
   initial begin
      forever #50 ref_clk = ~ref_clk;
   end
   // hang guard, well above the few thousand cycles the run needs
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         tally_and_finish();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // each task that drives a signal starts on an edge so no strobe is assigned twice in one step
   task automatic tally_and_finish();
      $display("checks %0d, mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic look(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic rst();
      @(posedge ref_clk);
      rst_n <= 1'b0;
      repeat (20) @(posedge ref_clk);
      rst_n <= 1'b1;
   endtask
   task automatic drive();
      @(posedge ref_clk);
      ctl_in <= cin;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe, so look there
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      `CHK(reg_rdata, e)
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      rst();
      foreach (rows[i]) begin
         if (rows[i].wr) wr(rows[i].addr, rows[i].data);
         rd(rows[i].addr, rows[i].exp);
      end
      rst();
      look(1);
      `CHK({cout.motor_power, cout.brake_output_n, cout.brake_output_oe, irq}, 4'h4)
      // unassigned output: servo-on must not touch the brake pin
      cin.servo_on = 1'b1;
      drive();
      look(5);
      `CHK({cout.brake_output_n, cout.brake_output_oe}, 2'b10)
      cin.servo_on = 1'b0;
      drive();
      look(3);
      `CHK(cout.motor_power, 1'b0)
      wr(`HBS_OFS_CTRL, 32'h1);
      look(1);
      `CHK(cout.brake_output_oe, 1'b1)
      wr(`HBS_OFS_OFF_DELAY, 32'h5);
      wr(`HBS_OFS_IRQ_MASK, 32'h0);
      cin.servo_on = 1'b1;
      drive();
      look(3);
      `CHK({cout.brake_output_n, cout.motor_power}, 2'b01)
      cin.over_travel = 1'b1;
      drive();
      look(3);
      `CHK(cout.brake_output_n, 1'b1)
      cin.over_travel = 1'b0;
      drive();
      look(3);
      `CHK(cout.brake_output_n, 1'b0)
      // stopped servo-off: brake first, power held for the 5 ms delay
      cin.servo_on = 1'b0;
      drive();
      look(3);
      `CHK({cout.brake_output_n, cout.motor_power}, 2'b11)
      look(32);
      `CHK(cout.motor_power, 1'b1)
      look(30);
      `CHK(cout.motor_power, 1'b0)
      `CHK(irq, 1'b0)
      rd(`HBS_OFS_IRQ_STAT, 32'h3);
      wr(`HBS_OFS_IRQ_MASK, 32'h1);
      look(2);
      `CHK(irq, 1'b1)
      wr(`HBS_OFS_IRQ_STAT, 32'h1);
      look(2);
      `CHK(irq, 1'b0)
      rd(`HBS_OFS_IRQ_STAT, 32'h2);
      // rotating stop, speed falls 1 rpm per clock from 500: threshold wins
      target_rpm <= 11'd500;
      decel_rpm <= 11'd1;
      cin.servo_on = 1'b1;
      drive();
      look(4);
      cin.servo_on = 1'b0;
      drive();
      look(3);
      `CHK({cout.brake_output_n, cout.motor_power}, 2'b00)
      look(374);
      `CHK(cout.brake_output_n, 1'b0)
      look(45);
      `CHK(cout.brake_output_n, 1'b1)
      // speed stuck above threshold: the 100 ms wait must apply the brake
      wr(`HBS_OFS_WAIT, 32'h64);
      decel_rpm <= 11'd0;
      cin.servo_on = 1'b1;
      drive();
      look(4);
      cin.servo_on = 1'b0;
      drive();
      look(900);
      `CHK(cout.brake_output_n, 1'b0)
      look(120);
      `CHK(cout.brake_output_n, 1'b1)
      // class-one fault while powered at standstill drops power at once
      target_rpm <= 11'd0;
      cin.servo_on = 1'b1;
      drive();
      look(4);
      cin.fault = 1'b1;
      drive();
      look(3);
      `CHK({cout.brake_output_n, cout.motor_power}, 2'b10)
      cin = '0;
      drive();
      look(80);
      // class-two fault while rotating uses the standstill timing, not the speed wait
      target_rpm <= 11'd500;
      cin.servo_on = 1'b1;
      drive();
      look(4);
      cin.fault = 1'b1;
      cin.fault_class2 = 1'b1;
      drive();
      look(3);
      `CHK(cout.brake_output_n, 1'b1)
      cin = '0;
      drive();
      look(80);
      // every phase-loss code with a missing phase
      cin.phase_lost = 1'b1;
      drive();
      for (int s = 0; s < 3; s++) begin
         wr(`HBS_OFS_PHASE_SEL, 32'(s));
         look(2);
         `CHK({cout.phase_fault, cout.phase_alarm}, {1'(s != 2), 1'(s == 1)})
      end
      // 10 ms nominal overload: fault after gain clocks, checked 15 clocks either side
      for (int k = 0; k < 3; k++) begin
         g = 50 + 50 * k;
         rst();
         cin = '0;
         drive();
         wr(`HBS_OFS_OVL_NOM, 32'hA);
         wr(`HBS_OFS_OVL_GAIN, 32'(g));
         cin.ovl_active = 1'b1;
         drive();
         look(g - 15);
         `CHK(cout.ovl_fault, 1'b0)
         look(30);
         `CHK(cout.ovl_fault, 1'b1)
      end
      // removing the assignment only takes hold after a power cycle
      wr(`HBS_OFS_CTRL, 32'h1);
      wr(`HBS_OFS_CTRL, 32'h0);
      look(2);
      `CHK(cout.brake_output_oe, 1'b1)
      rst();
      look(1);
      `CHK(cout.brake_output_oe, 1'b0)
      tally_and_finish();
   end
endmodule // hbs_brake_seq_bench
